// ===== lnevr_pkg.sv
package lnevr_pkg;

  localparam int unsigned SFR_AW = 8;
  localparam int unsigned SFR_DW = 8;

  localparam logic [7:0] ADDR_RX_SOURCE_SELECT = 8'hDA;
  localparam logic [7:0] ADDR_LIN_EVENT_INTERRUPT_ENABLES = 8'hD9;
  localparam logic [7:0] ADDR_LIN_EVENT_FLAGS = 8'hD8;

  localparam int unsigned BIT_SYNC_FOUND = 0;
  localparam int unsigned BIT_SYNC_TIMEOUT = 1;
  localparam int unsigned BIT_BREAK_DONE = 2;
  localparam int unsigned BIT_BREAK_REQUIRED = 3;
  localparam int unsigned RX_SEL_LSB = 0;
  localparam int unsigned RX_SEL_W = 2;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RX_SEL_RESET = 2'h0;

  typedef enum logic [1:0] {
    RX_CROSSBAR = 2'h0,
    RX_LOGIC_UNIT_ZERO = 2'h1,
    RX_LOGIC_UNIT_ONE = 2'h2,
    RX_LOGIC_UNIT_TWO = 2'h3
  } lnevr_rx_sel_t;

  typedef enum logic [1:0] {
    BRK_WAIT = 2'h0,
    BRK_SEEN = 2'h1
  } lnevr_brk_state_t;

  // One bit per LIN event, same order as the flag register
  typedef struct packed {
    logic break_done;
    logic sync_timeout;
    logic sync_found;
  } lnevr_events_t;

  typedef struct packed {
    logic [SFR_AW-1:0] addr;
    logic wr;
    logic rd;
    logic [SFR_DW-1:0] wdata;
  } lnevr_sfr_req_t;

endpackage

// ===== lnevr_sync2.sv
`timescale 1ns/1ns
module lnevr_sync2 #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic async_i, // Level from outside the clock domain
  output logic sync_o // Synchronised level
);
  logic stage1;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      stage1 <= RESET_LEVEL;
      sync_o <= RESET_LEVEL;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// ===== lnevr_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Break-required: sync only after break and delimiter.
// - Break-done enable, bit 2, gates its interrupt.
// - Sync-timeout enable, bit 1, gates its interrupt.
// - Sync-found enable, bit 0, gates its interrupt.
// - Two-bit receive source: crossbar or logic units.
// - Sync-found flag set by hardware, cleared writing 0.
// - Timeout flag set; baud value left unchanged.
module lnevr_top #(
  parameter int unsigned BAUD_W = 16
) (
  input wire logic clk_sys_i, // System clock, 125 MHz
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic [7:0] sfr_addr_i, // Register address
  input wire logic sfr_wr_i, // Register write strobe
  input wire logic sfr_rd_i, // Register read strobe
  input wire logic [7:0] sfr_wdata_i, // Register write data
  output logic [7:0] sfr_rdata_o, // Register read data
  input wire logic break_done_evt_i, // Break and delimiter seen, pulse
  input wire logic sync_timeout_evt_i, // Sync measurement overflow, pulse
  input wire logic sync_found_evt_i, // Sync word measured, pulse
  input wire logic [BAUD_W-1:0] baud_measured_i, // Measured baud value
  output logic [BAUD_W-1:0] baud_value_o, // Baud generator reload value
  output logic baud_load_o, // Baud value updated, pulse
  output logic break_required_o, // Break-required option level
  output logic lin_irq_o, // LIN part of UART interrupt request
  input wire logic rx_pin_i, // Crossbar receive pin, asynchronous
  input wire logic logic_unit_zero_out_i, // Logic unit zero output
  input wire logic logic_unit_one_out_i, // Logic unit one output
  input wire logic logic_unit_two_out_i, // Logic unit two output
  output logic rx_o // Selected receive input to the UART
);
  // Refused at elaboration, not merely reported at run time
  if (BAUD_W < 1 || BAUD_W > 32) begin : g_baud_w_check
    $error("BAUD_W out of range");
  end

  lnevr_pkg::lnevr_sfr_req_t req;
  lnevr_pkg::lnevr_events_t evt;
  lnevr_pkg::lnevr_events_t flags;
  lnevr_pkg::lnevr_events_t irq_en;
  lnevr_pkg::lnevr_events_t next_flags;
  lnevr_pkg::lnevr_brk_state_t brk_state;
  lnevr_pkg::lnevr_rx_sel_t rx_source_sel;
  logic break_required;
  logic sync_accept;
  logic rx_pin_sync;
  logic next_rx;

  assign req = '{addr: sfr_addr_i, wr: sfr_wr_i, rd: sfr_rd_i, wdata: sfr_wdata_i};

  lnevr_sync2 #(
    .RESET_LEVEL(1'b1)
  ) u_rx_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .async_i(rx_pin_i),
    .sync_o(rx_pin_sync)
  );

  // A sync word counts only once a break has been seen when required
  assign sync_accept = sync_found_evt_i && !sync_timeout_evt_i &&
                       (!break_required || brk_state == lnevr_pkg::BRK_SEEN);

  assign evt.break_done = break_done_evt_i;
  assign evt.sync_timeout = sync_timeout_evt_i;
  assign evt.sync_found = sync_accept;

  // Break tracking; a timeout or a sync ends the frame attempt
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      brk_state <= lnevr_pkg::BRK_WAIT;
    end else begin
      unique case (brk_state)
        lnevr_pkg::BRK_WAIT: begin
          if (break_done_evt_i) begin
            brk_state <= lnevr_pkg::BRK_SEEN;
          end
        end
        lnevr_pkg::BRK_SEEN: begin
          if ((sync_found_evt_i || sync_timeout_evt_i) && !break_done_evt_i) begin
            brk_state <= lnevr_pkg::BRK_WAIT;
          end
        end
        default: begin
          brk_state <= lnevr_pkg::BRK_WAIT;
        end
      endcase
    end
  end

  // Writing 0 clears a flag; a same-cycle event wins over the clear
  always_comb begin
    next_flags = flags;
    if (req.wr && req.addr == lnevr_pkg::ADDR_LIN_EVENT_FLAGS) begin
      next_flags.break_done = flags.break_done &
                              req.wdata[lnevr_pkg::BIT_BREAK_DONE];
      next_flags.sync_timeout = flags.sync_timeout &
                                req.wdata[lnevr_pkg::BIT_SYNC_TIMEOUT];
      next_flags.sync_found = flags.sync_found &
                              req.wdata[lnevr_pkg::BIT_SYNC_FOUND];
    end
    next_flags = next_flags | evt;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irq_en <= '0;
      break_required <= 1'b0;
    end else if (req.wr && req.addr == lnevr_pkg::ADDR_LIN_EVENT_INTERRUPT_ENABLES) begin
      irq_en.break_done <= req.wdata[lnevr_pkg::BIT_BREAK_DONE];
      irq_en.sync_timeout <= req.wdata[lnevr_pkg::BIT_SYNC_TIMEOUT];
      irq_en.sync_found <= req.wdata[lnevr_pkg::BIT_SYNC_FOUND];
      break_required <= req.wdata[lnevr_pkg::BIT_BREAK_REQUIRED];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rx_source_sel <= lnevr_pkg::lnevr_rx_sel_t'(lnevr_pkg::RX_SEL_RESET);
    end else if (req.wr && req.addr == lnevr_pkg::ADDR_RX_SOURCE_SELECT) begin
      rx_source_sel <= lnevr_pkg::lnevr_rx_sel_t'(
        req.wdata[lnevr_pkg::RX_SEL_LSB +: lnevr_pkg::RX_SEL_W]);
    end
  end

  // Overflowed measurement never reaches the baud generator
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      baud_value_o <= '0;
      baud_load_o <= 1'b0;
    end else begin
      baud_load_o <= sync_accept;
      if (sync_accept) begin
        baud_value_o <= baud_measured_i;
      end
    end
  end

  // Level output: stays high until software clears the flags or their enables
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      lin_irq_o <= 1'b0;
    end else begin
      lin_irq_o <= |(next_flags & irq_en);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      break_required_o <= 1'b0;
    end else begin
      break_required_o <= break_required;
    end
  end

  always_comb begin
    unique case (rx_source_sel)
      lnevr_pkg::RX_CROSSBAR: next_rx = rx_pin_sync;
      lnevr_pkg::RX_LOGIC_UNIT_ZERO: next_rx = logic_unit_zero_out_i;
      lnevr_pkg::RX_LOGIC_UNIT_ONE: next_rx = logic_unit_one_out_i;
      lnevr_pkg::RX_LOGIC_UNIT_TWO: next_rx = logic_unit_two_out_i;
    endcase
  end

  // Idle-high line so the UART sees no false start out of reset
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rx_o <= 1'b1;
    end else begin
      rx_o <= next_rx;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= lnevr_pkg::RESET_BYTE;
    end else if (req.rd) begin
      sfr_rdata_o <= lnevr_pkg::RESET_BYTE;
      unique case (req.addr)
        lnevr_pkg::ADDR_RX_SOURCE_SELECT: begin
          sfr_rdata_o[lnevr_pkg::RX_SEL_LSB +: lnevr_pkg::RX_SEL_W] <= rx_source_sel;
        end
        lnevr_pkg::ADDR_LIN_EVENT_INTERRUPT_ENABLES: begin
          sfr_rdata_o[lnevr_pkg::BIT_BREAK_DONE:lnevr_pkg::BIT_SYNC_FOUND] <= irq_en;
          sfr_rdata_o[lnevr_pkg::BIT_BREAK_REQUIRED] <= break_required;
        end
        lnevr_pkg::ADDR_LIN_EVENT_FLAGS: begin
          sfr_rdata_o[lnevr_pkg::BIT_BREAK_DONE:lnevr_pkg::BIT_SYNC_FOUND] <= flags;
        end
        default: begin
          sfr_rdata_o <= lnevr_pkg::RESET_BYTE;
        end
      endcase
    end
  end
endmodule

// ===== lnevr_checker.sv
`timescale 1ns/1ns
module lnevr_checker #(
  parameter int unsigned BAUD_W = 16
) (
  input wire logic clk_sys_i, // Clock
  input wire logic rstn_i, // Reset
  input wire logic [7:0] sfr_addr_i, // Address
  input wire logic sfr_wr_i, // Write
  input wire logic [7:0] sfr_wdata_i, // Data
  input wire logic break_done_evt_i, // Event
  input wire logic sync_timeout_evt_i, // Event
  input wire logic sync_found_evt_i, // Event
  input wire logic [BAUD_W-1:0] baud_measured_i, // Value
  input wire logic [BAUD_W-1:0] baud_value_o, // Value
  input wire logic baud_load_o, // Pulse
  input wire logic break_required_o, // Option
  input wire logic lin_irq_o, // Interrupt
  input wire logic rx_pin_i, // Pin
  input wire logic logic_unit_zero_out_i, // Unit
  input wire logic logic_unit_one_out_i, // Unit
  input wire logic logic_unit_two_out_i, // Unit
  input wire logic rx_o // Receive
);
  logic [2:0] en;
  logic [1:0] sel;
  logic brk;
  wire w_en = sfr_wr_i && sfr_addr_i == lnevr_pkg::ADDR_LIN_EVENT_INTERRUPT_ENABLES;
  wire w_sel = sfr_wr_i && sfr_addr_i == lnevr_pkg::ADDR_RX_SOURCE_SELECT;
  wire unit = sel == 2'h1 ? logic_unit_zero_out_i :
    sel == 2'h2 ? logic_unit_one_out_i : logic_unit_two_out_i;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) en <= 3'h0;
    else if (w_en) en <= sfr_wdata_i[2:0];
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) sel <= 2'h0;
    else if (w_sel) sel <= sfr_wdata_i[1:0];
  end
  // Break wins over a sync or timeout in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) brk <= 1'b0;
    else if (break_done_evt_i || sync_found_evt_i || sync_timeout_evt_i) brk <= break_done_evt_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence quiet_s; en == 3'h0 ##1 en == 3'h0; endsequence
  sequence lone_sync_s; sync_found_evt_i && break_required_o && !brk && !break_done_evt_i;
  endsequence
  brk_need_a: assert property (lone_sync_s |=> !baud_load_o && $stable(baud_value_o))
    else $error("sync taken without break");
  brk_irq_a: assert property (break_done_evt_i && en[2] |=> lin_irq_o)
    else $error("break irq missing");
  to_irq_a: assert property (sync_timeout_evt_i && en[1] |=> lin_irq_o)
    else $error("timeout irq missing");
  sync_irq_a: assert property (baud_load_o && en[0] |-> lin_irq_o)
    else $error("sync irq missing");
  rx_unit_a: assert property (sel != 2'h0 |=> rx_o == $past(unit))
    else $error("rx unit route wrong");
  rx_pin_a: assert property (sel == 2'h0 [*4] |-> rx_o == $past(rx_pin_i, 3))
    else $error("rx pin route wrong");
  baud_val_a: assert property (baud_load_o |->
    $past(sync_found_evt_i) && baud_value_o == $past(baud_measured_i)) else $error("baud wrong");
  to_nobaud_a: assert property (sync_timeout_evt_i |=> !baud_load_o && $stable(baud_value_o))
    else $error("timeout moved baud");
  irq_gate_a: assert property (quiet_s |-> !lin_irq_o)
    else $error("irq without enable");
  load_pulse_a: assert property (!sync_found_evt_i |=> !baud_load_o)
    else $error("load not a pulse");
endmodule

// ===== lnevr_lin_peer.sv
`timescale 1ns/1ns
module lnevr_lin_peer (
  input wire logic clk_sys_i, // Clock
  output logic brk_o = 1'b0, // Break done pulse
  output logic to_o = 1'b0, // Timeout pulse
  output logic sync_o = 1'b0, // Sync pulse
  output logic [15:0] baud_o = 16'h0000, // Measured value
  output logic [2:0] unit_o = 3'h0, // Logic unit outputs
  output logic pin_o = 1'b1 // Crossbar pin, idles high
);
  // Kind 0 sync, 1 timeout, 2 break
  task automatic pulse(input int k, input logic [15:0] b);
    @(posedge clk_sys_i);
    #1;
    baud_o = b;
    {brk_o, to_o, sync_o} = 3'h1 << k;
    @(posedge clk_sys_i);
    #1;
    {brk_o, to_o, sync_o} = 3'h0;
    // Value is not held once the pulse is gone
    baud_o = ~b;
  endtask
  task automatic lines(input logic [3:0] v);
    @(posedge clk_sys_i);
    #1;
    {unit_o, pin_o} = v;
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] SRC = lnevr_pkg::ADDR_RX_SOURCE_SELECT;
  localparam logic [7:0] EN = lnevr_pkg::ADDR_LIN_EVENT_INTERRUPT_ENABLES;
  localparam logic [7:0] FL = lnevr_pkg::ADDR_LIN_EVENT_FLAGS;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic break_done_evt_i, sync_timeout_evt_i, sync_found_evt_i, rx_pin_i, rx_o;
  logic logic_unit_zero_out_i, logic_unit_one_out_i, logic_unit_two_out_i;
  logic baud_load_o, break_required_o, lin_irq_o;
  logic [15:0] baud_measured_i, baud_value_o;
  int err_total = 0, samples_checked = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  lnevr_top i_lnevr_top (.clk_sys_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .sfr_rdata_o, .break_done_evt_i, .sync_timeout_evt_i, .sync_found_evt_i, .baud_measured_i,
    .baud_value_o, .baud_load_o, .break_required_o, .lin_irq_o, .rx_pin_i,
    .logic_unit_zero_out_i, .logic_unit_one_out_i, .logic_unit_two_out_i, .rx_o);
  lnevr_lin_peer i_peer (.clk_sys_i, .brk_o(break_done_evt_i), .to_o(sync_timeout_evt_i),
    .sync_o(sync_found_evt_i), .baud_o(baud_measured_i), .pin_o(rx_pin_i),
    .unit_o({logic_unit_two_out_i, logic_unit_one_out_i, logic_unit_zero_out_i}));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    #1;
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    sfr_rd_i = 1'b0;
    chk({8'h00, sfr_rdata_o}, {8'h00, exp});
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    conclude();
  end
  initial begin
    logic [3:0] v;
    repeat (16) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    rd8(SRC, 8'h00);
    rd8(EN, 8'h00);
    wr8(EN, 8'hFF);
    rd8(EN, 8'h0F);
    rd8(8'hD7, 8'h00);
    $display("test map done");
    wr8(EN, 8'h08);
    i_peer.pulse(0, 16'h1234);
    rd8(FL, 8'h00);
    chk({15'h0, break_required_o}, 16'h0001);
    i_peer.pulse(2, 16'h0000);
    i_peer.pulse(0, 16'h1234);
    chk(baud_value_o, 16'h1234);
    chk({15'h0, baud_load_o}, 16'h0001);
    rd8(FL, 8'h05);
    chk({15'h0, lin_irq_o}, 16'h0000);
    wr8(FL, 8'h04);
    rd8(FL, 8'h04);
    $display("test break done");
    wr8(FL, 8'h00);
    wr8(EN, 8'h02);
    i_peer.pulse(1, 16'h5555);
    chk({15'h0, lin_irq_o}, 16'h0001);
    chk(baud_value_o, 16'h1234);
    rd8(FL, 8'h02);
    $display("test timeout done");
    for (int e = 0; e < 3; e++) begin
      for (int k = 0; k < 3; k++) begin
        wr8(FL, 8'h00);
        wr8(EN, 8'h01 << e);
        i_peer.pulse(k, 16'h0100);
        chk({15'h0, lin_irq_o}, {15'h0, e == k});
      end
    end
    wr8(FL, 8'h00);
    @(posedge clk_sys_i);
    #1;
    chk({15'h0, lin_irq_o}, 16'h0000);
    $display("test enables done");
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        v = p ? 4'hA : 4'h5;
        i_peer.lines(v);
        wr8(SRC, s[7:0]);
        rd8(SRC, s[7:0]);
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk({15'h0, rx_o}, {15'h0, v[s]});
      end
    end
    $display("test routing done");
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    chk({15'h0, rx_o}, 16'h0001);
    rd8(EN, 8'h00);
    rd8(SRC, 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule
bind lnevr_top lnevr_checker #(.BAUD_W(BAUD_W)) i_chk (.clk_sys_i, .rstn_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_wdata_i, .break_done_evt_i, .sync_timeout_evt_i, .sync_found_evt_i,
  .baud_measured_i, .baud_value_o, .baud_load_o, .break_required_o, .lin_irq_o, .rx_pin_i,
  .logic_unit_zero_out_i, .logic_unit_one_out_i, .logic_unit_two_out_i, .rx_o);
